/* hdl/silo_map.svh */
// Constants of the interlock output logic: timing counts and reset values.
// Assumes a 125 MHz system clock.
`ifndef SILO_MAP_SVH
`define SILO_MAP_SVH

`define SILO_CLK_MHZ        125
`define SILO_FILT_NS        32
`define SILO_FILT_CYC       ((`SILO_FILT_NS * `SILO_CLK_MHZ + 999) / 1000)
`define SILO_TEACH_MAX      4'h8
`define SILO_MAX_SUBSCR     5'h10
`define SILO_ADDR_W         4
`define SILO_FRAME_W        8
// Serial bits last several clocks so that the pin agreement filter keeps them
`define SILO_BIT_CYC        4'h4
`define SILO_BIT_FIRST      4'h5
`define SILO_CMD_STATE      2'h0
`define SILO_CMD_TEACH      2'h1
`define SILO_CMD_SERIAL     2'h2
`define SILO_CMD_NAME       2'h3

`endif

/* hdl/silo_pkg.sv */
// Types of the interlock output logic.
// Assumes silo_map.svh is compiled alongside.
package silo_pkg;

    typedef struct packed {
        logic ch1;
        logic ch2;
        logic act;
    } silo_in_t;

    typedef enum logic [1:0] {
        SILO_NORMAL  = 2'h0,
        SILO_UNEQUAL = 2'h1,
        SILO_LOCKED  = 2'h3,
        SILO_BOTHLOW = 2'h2
    } silo_plaus_t;

    typedef enum logic [1:0] {
        SILO_D_IDLE = 2'h0,
        SILO_D_RECV = 2'h1,
        SILO_D_SEND = 2'h3
    } silo_diag_t;

endpackage : silo_pkg

/* hdl/silo_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module silo_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;

    // ==========================================
    // Agreement filter
    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : silo_sync
`default_nettype wire

/* hdl/silo_top.sv */
// Output logic of a transponder safety interlock switch.
// Assumes asynchronous pins, a 125 MHz clock and a host-supplied actuator tag.
`timescale 1ns/1ps
`default_nettype none
`include "silo_map.svh"

// Contract
// - Each output channel high only with actuator present and its input high.
// - Safe condition or no actuator forces both outputs off.
// - Without diagnostics, signal output follows actuator detection.
// - Mapping applies only while ready, shown by green power indicator.
// - One input falling while other high flags unequal, input indicator flashes.
// - Same input rising again flags plausibility error and partial lock.
// - Lock clears only after both inputs seen low together.
// - With fieldbus module attached, diagnostics input is enabled and read.
// - Without fieldbus module, diagnostics input is ignored.
// - With fieldbus module, signal output carries diagnostic data.
// - Chain supports up to 16 subscribers.
// - Diagnostics communication restarts automatically after every power-up.
// - Answer state, teach count, serial number and actuator name polls.
// - Diagnostics never alter the safety path.
// - First detected actuator is learned; only learned actuators accepted.
// - At most 8 learning procedures, count drops per completed one.
module silo_top
    import silo_pkg::*;
#(
    parameter logic [`SILO_ADDR_W-1:0] SUB_ADDR = 4'h0,
    parameter logic [7:0]              SERIAL   = 8'h5A  // Arbitrary value
) (
    // System
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // Safety inputs and detection
    input  wire logic        SAFETY_IN_CH1,
    input  wire logic        SAFETY_IN_CH2,
    input  wire logic        ACT_PRESENT,
    input  wire logic [7:0]  ACT_TAG,
    input  wire logic        LEARN_DONE,
    input  wire logic        READY,
    // Diagnostics chain
    input  wire logic        BUS_ATTACHED,
    input  wire logic        DIAG_IN,
    // Outputs
    output logic             SAFETY_OUT_CH1,
    output logic             SAFETY_OUT_CH2,
    output logic             SIGNAL_DIAG_OUT,
    output logic             LED_GREEN,
    output logic             LED_INPUT_FLASH,
    output logic             PLAUS_ERR,
    output logic [3:0]       TEACH_LEFT
);
    import silo_pkg::*;

    // ==========================================
    // Input synchronisation
    silo_in_t raw, flt;
    logic [1:0] dsync;
    assign raw = '{ch1: SAFETY_IN_CH1, ch2: SAFETY_IN_CH2, act: ACT_PRESENT};

    silo_sync #(.W(3)) u_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     (raw),
        .q     (flt)
    );
    silo_sync #(.W(2)) u_dsync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     ({BUS_ATTACHED, DIAG_IN}),
        .q     (dsync)
    );

    // ==========================================
    // Actuator learning
    logic       learned_r, learned_nxt;
    logic [7:0] tag_r, tag_nxt;
    logic [3:0] left_r, left_nxt;
    logic       act_ok;

    always_comb begin
        learned_nxt = learned_r;
        tag_nxt     = tag_r;
        left_nxt    = left_r;
        if (flt.act && !learned_r) begin
            learned_nxt = 1'b1;
            tag_nxt     = ACT_TAG;
        end else if (LEARN_DONE && flt.act && left_r != 4'h0) begin
            tag_nxt  = ACT_TAG;
            left_nxt = left_r - 4'h1;
        end
    end
    assign act_ok = flt.act && learned_r && (ACT_TAG == tag_r);

    // ==========================================
    // Plausibility monitor
    silo_plaus_t st_r, st_nxt;
    logic        ch1_q_r, ch2_q_r;

    always_comb begin
        st_nxt   = st_r;
        unique case (st_r)
            SILO_NORMAL: begin
                if (ch1_q_r && !flt.ch1 && flt.ch2) begin
                    st_nxt = SILO_UNEQUAL;
                end else if (ch2_q_r && !flt.ch2 && flt.ch1) begin
                    st_nxt = SILO_UNEQUAL;
                end
            end
            SILO_UNEQUAL: begin
                if (!flt.ch1 && !flt.ch2) begin
                    st_nxt = SILO_BOTHLOW;
                end else if (flt.ch1 && flt.ch2) begin
                    st_nxt = SILO_LOCKED;
                end
            end
            SILO_LOCKED: begin
                if (!flt.ch1 && !flt.ch2) begin
                    st_nxt = SILO_BOTHLOW;
                end
            end
            SILO_BOTHLOW: begin
                if (flt.ch1 || flt.ch2) begin
                    st_nxt = SILO_NORMAL;
                end
            end
        endcase
    end

    // ==========================================
    // Safety outputs, independent of diagnostics
    logic out1_nxt, out2_nxt, sig_nxt;
    logic out1_r, out2_r, sig_r, green_r, flash_r, perr_r;
    logic run;
    assign run = READY && (st_r != SILO_LOCKED);

    always_comb begin
        out1_nxt = run && act_ok && flt.ch1;
        out2_nxt = run && act_ok && flt.ch2;
    end

    // ==========================================
    // Diagnostics chain: frame = start, 2-bit cmd, 4-bit address; reply 8 bits
    silo_diag_t dst_r, dst_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [3:0] ph_r, ph_nxt;
    logic       din_q_r;
    logic       attached;
    assign attached = dsync[1];

    function automatic logic [7:0] silo_reply(input logic [1:0] cmd);
        unique case (cmd)
            `SILO_CMD_STATE:  silo_reply = {5'h00, out1_r, out2_r, act_ok};
            `SILO_CMD_TEACH:  silo_reply = {4'h0, left_r};
            `SILO_CMD_SERIAL: silo_reply = SERIAL;
            `SILO_CMD_NAME:   silo_reply = tag_r;
        endcase
    endfunction : silo_reply

    always_comb begin
        dst_nxt = dst_r;
        sh_nxt  = sh_r;
        cnt_nxt = cnt_r;
        ph_nxt  = ph_r;
        sig_nxt = flt.act;
        unique case (dst_r)
            SILO_D_IDLE: begin
                if (attached && din_q_r && !dsync[0]) begin
                    dst_nxt = SILO_D_RECV;
                    cnt_nxt = 4'h0;
                    ph_nxt  = `SILO_BIT_FIRST;                   // Middle of first command bit
                end
            end
            SILO_D_RECV: begin
                if (ph_r != 4'h0) begin
                    ph_nxt = ph_r - 4'h1;
                end else begin
                    ph_nxt  = `SILO_BIT_CYC - 4'h1;
                    sh_nxt  = {sh_r[6:0], dsync[0]};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'h5) begin
                        if ({sh_r[2:0], dsync[0]} == SUB_ADDR) begin
                            dst_nxt = SILO_D_SEND;
                            sh_nxt  = silo_reply(sh_r[4:3]);
                            cnt_nxt = 4'h0;
                        end else begin
                            dst_nxt = SILO_D_IDLE;
                        end
                    end
                end
            end
            SILO_D_SEND: begin
                if (ph_r != 4'h0) begin
                    ph_nxt = ph_r - 4'h1;
                end else begin
                    ph_nxt  = `SILO_BIT_CYC - 4'h1;
                    sh_nxt  = {sh_r[6:0], 1'b0};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'h7) begin
                        dst_nxt = SILO_D_IDLE;
                    end
                end
            end
            default: dst_nxt = SILO_D_IDLE;
        endcase
        if (attached) begin
            sig_nxt = (dst_r == SILO_D_SEND) ? sh_r[7] : 1'b1;
        end
        if (!attached) begin
            dst_nxt = SILO_D_IDLE;
        end
    end

    // ==========================================
    // Registers; reset restarts the chain
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            learned_r <= 1'b0;
            tag_r     <= 8'h00;
            left_r    <= `SILO_TEACH_MAX;
            st_r      <= SILO_NORMAL;
            ph_r      <= 4'h0;
            ch1_q_r   <= 1'b0;
            ch2_q_r   <= 1'b0;
            out1_r    <= 1'b0;
            out2_r    <= 1'b0;
            sig_r     <= 1'b0;
            green_r   <= 1'b0;
            flash_r   <= 1'b0;
            perr_r    <= 1'b0;
            dst_r     <= SILO_D_IDLE;
            sh_r      <= 8'h00;
            cnt_r     <= 4'h0;
            din_q_r   <= 1'b1;
        end else begin
            learned_r <= learned_nxt;
            tag_r     <= tag_nxt;
            left_r    <= left_nxt;
            st_r      <= st_nxt;
            ph_r      <= ph_nxt;
            ch1_q_r   <= flt.ch1;
            ch2_q_r   <= flt.ch2;
            out1_r    <= out1_nxt;
            out2_r    <= out2_nxt;
            sig_r     <= sig_nxt;
            green_r   <= READY;
            flash_r   <= (st_nxt == SILO_UNEQUAL) || (st_nxt == SILO_LOCKED);
            perr_r    <= (st_nxt == SILO_LOCKED);
            dst_r     <= dst_nxt;
            sh_r      <= sh_nxt;
            cnt_r     <= cnt_nxt;
            din_q_r   <= dsync[0];
        end
    end

    assign SAFETY_OUT_CH1  = out1_r;
    assign SAFETY_OUT_CH2  = out2_r;
    assign SIGNAL_DIAG_OUT = sig_r;
    assign LED_GREEN       = green_r;
    assign LED_INPUT_FLASH = flash_r;
    assign PLAUS_ERR       = perr_r;
    assign TEACH_LEFT      = left_r;
endmodule : silo_top
`default_nettype wire

/* bench/silo_eval.sv */
// Evaluation device model watching both safety output channels.
// Assumes both channels are sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module silo_eval (
    // Channels
    input  wire logic clk,
    input  wire logic ch1,
    input  wire logic ch2,
    output var  logic run_ok
);
    // ====================
    // Release
    // Two-channel release: one channel alone never releases
    always_ff @(posedge clk) begin
        run_ok <= ch1 & ch2;
    end
endmodule : silo_eval
`default_nettype wire

/* bench/silo_top_chk.sv */
// Property checker for the interlock output logic.
// Assumes it is bound into silo_top and sees only its pins.
`timescale 1ns/1ps
`default_nettype none
module silo_chk (
    // Pins
    input wire logic       CLOCK,
    input wire logic       RST_N,
    input wire logic       SAFETY_IN_CH1,
    input wire logic       ACT_PRESENT,
    input wire logic       READY,
    input wire logic       BUS_ATTACHED,
    input wire logic       SAFETY_OUT_CH1,
    input wire logic       SAFETY_OUT_CH2,
    input wire logic       SIGNAL_DIAG_OUT,
    input wire logic       LED_INPUT_FLASH,
    input wire logic       PLAUS_ERR,
    input wire logic [3:0] TEACH_LEFT
);
    // ====================
    // Properties
    // Eight cycles cover sync, filter and output flop with margin
    wire logic both_off = !SAFETY_OUT_CH1 && !SAFETY_OUT_CH2;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    chk_ch1_off: assert property (
        (!SAFETY_IN_CH1)[*8] |-> !SAFETY_OUT_CH1) else $error("out1 high, in1 low");
    chk_noact_off: assert property (
        (!ACT_PRESENT)[*8] |-> both_off) else $error("outputs on, no actuator");
    chk_notready_off: assert property (
        (!READY)[*8] |-> both_off) else $error("outputs on, not ready");
    chk_sig_low: assert property (
        (!BUS_ATTACHED && !ACT_PRESENT)[*8] |-> !SIGNAL_DIAG_OUT) else $error("signal high");
    chk_sig_high: assert property (
        (!BUS_ATTACHED && ACT_PRESENT && READY)[*8] |-> SIGNAL_DIAG_OUT) else $error("signal low");
    chk_err_flash: assert property (
        PLAUS_ERR |-> LED_INPUT_FLASH) else $error("lock without flashing");
    chk_lock_off: assert property (
        PLAUS_ERR && $past(PLAUS_ERR) |-> both_off) else $error("outputs on while locked");
    chk_teach_step: assert property (
        $changed(TEACH_LEFT) |-> TEACH_LEFT == $past(TEACH_LEFT) - 4'h1) else $error("teach step");
endmodule : silo_chk
bind silo_top silo_chk u_chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .SAFETY_IN_CH1(SAFETY_IN_CH1), .ACT_PRESENT(ACT_PRESENT),
    .READY(READY), .BUS_ATTACHED(BUS_ATTACHED), .SAFETY_OUT_CH1(SAFETY_OUT_CH1),
    .SAFETY_OUT_CH2(SAFETY_OUT_CH2), .SIGNAL_DIAG_OUT(SIGNAL_DIAG_OUT),
    .LED_INPUT_FLASH(LED_INPUT_FLASH), .PLAUS_ERR(PLAUS_ERR), .TEACH_LEFT(TEACH_LEFT));
`default_nettype wire

/* bench/test_safety_interlock_output_logic.sv */
// Self-checking bench for the interlock output logic.
// Assumes silo_pkg, the design and bench models compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "silo_map.svh"
module test_safety_interlock_output_logic;
    import silo_pkg::*;
    // ====================
    // Stimulus and scoreboard
    localparam logic [7:0] SER   = 8'h3C;  // Arbitrary value
    localparam logic [2:0] TT[8] = '{3'h7, 3'h1, 3'h5, 3'h1, 3'h3, 3'h0, 3'h6, 3'h7};
    logic        clk = 1'b0, rst_n = 1'b0, learn = 1'b0, rdy = 1'b1, bus = 1'b0, din = 1'b1;
    logic        probe = 1'b0, use_rx = 1'b0, o1, o2, sig, grn, fl, err, ok;
    silo_in_t    pin = '0;
    logic [7:0]  tag, rx, want[4];
    logic [3:0]  tl, texp = 4'h8;
    logic [31:0] rng = 32'h455374C6;
    logic [10:0] exp_q[$];
    int          err_count = 0;
    int          compares = 0;
    wire logic [10:0] seen = use_rx ? {3'h0, rx} : {o1, o2, sig, grn, fl, err, ok, tl};
    silo_top #(.SUB_ADDR(4'h0), .SERIAL(SER)) dut (.CLOCK(clk), .RST_N(rst_n),
        .SAFETY_IN_CH1(pin.ch1), .SAFETY_IN_CH2(pin.ch2), .ACT_PRESENT(pin.act), .ACT_TAG(tag),
        .LEARN_DONE(learn), .READY(rdy), .BUS_ATTACHED(bus), .DIAG_IN(din),
        .SAFETY_OUT_CH1(o1), .SAFETY_OUT_CH2(o2), .SIGNAL_DIAG_OUT(sig), .LED_GREEN(grn),
        .LED_INPUT_FLASH(fl), .PLAUS_ERR(err), .TEACH_LEFT(tl));
    silo_eval u_eval (.clk(clk), .ch1(o1), .ch2(o2), .run_ok(ok));
    always #4 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Lock forces both channels off whatever the inputs
    function automatic logic [10:0] st(input logic [2:0] v, input logic f, input logic e);
        logic a, b;
        a = v[2] & v[0] & !e;
        b = v[1] & v[0] & !e;
        return {a, b, v[0], 1'b1, f, e, a & b, texp};
    endfunction : st
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic note(input logic [10:0] exp);
        exp_q.push_back(exp);
        probe <= 1'b1;
        @(negedge clk);
        probe <= 1'b0;
        @(negedge clk);
    endtask : note
    task automatic apply(input logic [2:0] v);
        pin <= silo_in_t'(v);
        repeat (10) @(negedge clk);
    endtask : apply
    task automatic frame(input logic [1:0] cmd, input logic [3:0] adr);
        logic [6:0] f;
        f = {1'b0, cmd, adr};
        for (int i = 6; i >= 0; i--) begin
            din <= f[i];
            repeat (`SILO_BIT_CYC) @(negedge clk);
        end
        din <= 1'b1;
    endtask : frame
    // Every reply here is below 8'h80, so its first bit is a low start marker
    task automatic reply(input logic [7:0] exp);
        int n;
        n = 0;
        while (sig !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            err_count++;
            close_out();
        end else begin
            // Sample one and a half clocks into each bit, clear of both of its edges
            @(negedge clk);
            for (int i = 7; i >= 0; i--) begin
                rx[i] = sig;
                repeat (`SILO_BIT_CYC) @(negedge clk);
            end
            use_rx <= 1'b1;
            note({3'h0, exp});
            use_rx <= 1'b0;
        end
    endtask : reply
    task automatic quiet();
        rx = 8'hFF;
        repeat (20) begin
            @(negedge clk);
            rx[0] = rx[0] & sig;
        end
        use_rx <= 1'b1;
        note(11'h0FF);
        use_rx <= 1'b0;
    endtask : quiet
    always @(negedge clk) begin
        if (probe) begin
            check(seen, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial begin
        rng = xs(rng);
        tag = {1'b0, rng[6:0]};
        repeat (3) @(negedge clk);
        rst_n <= 1'b1;
        foreach (TT[i]) begin
            apply(TT[i]);
            note(st(TT[i], 1'b0, 1'b0));
        end
        pin.ch1 <= 1'b0;
        @(negedge clk);
        apply(3'h7);
        note(st(3'h7, 1'b0, 1'b0));
        apply(3'h3);
        note(st(3'h3, 1'b1, 1'b0));
        apply(3'h7);
        note(st(3'h7, 1'b1, 1'b1));
        apply(3'h1);
        apply(3'h7);
        note(st(3'h7, 1'b0, 1'b0));
        rdy <= 1'b0;
        apply(3'h7);
        note({7'h10, texp});
        rdy <= 1'b1;
        apply(3'h7);
        note(st(3'h7, 1'b0, 1'b0));
        // A foreign actuator must not release the outputs
        tag <= tag ^ 8'h01;
        apply(3'h7);
        note({7'h18, texp});
        tag <= tag ^ 8'h01;
        for (int i = 0; i < 9; i++) begin
            learn <= 1'b1;
            @(negedge clk);
            learn <= 1'b0;
            apply(3'h7);
            texp = (texp == 4'h0) ? 4'h0 : texp - 4'h1;
            note(st(3'h7, 1'b0, 1'b0));
        end
        frame(2'h2, 4'h0);
        quiet();
        bus <= 1'b1;
        apply(3'h7);
        want = '{8'h07, {4'h0, texp}, SER, tag};
        for (int c = 0; c < 4; c++) begin
            frame(c[1:0], 4'h0);
            reply(want[c]);
        end
        frame(2'h2, 4'h5);
        quiet();
        rst_n <= 1'b0;
        repeat (4) @(negedge clk);
        rst_n <= 1'b1;
        apply(3'h7);
        frame(2'h2, 4'h0);
        reply(SER);
        close_out();
    end
endmodule : test_safety_interlock_output_logic
`default_nettype wire
